// *** pm_status_smi_logic.sv ***
`timescale 1ns/10ps
module pm_status_smi_logic
   import pm_smi_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire pm_smi_pkg::cfg_req_s cfg_req,
   input wire logic ext_func_mode,
   output logic [7:0] cfg_rdata,
   input wire logic chip_power_mgmt_enable,
   input wire logic [3:0] device_pm_enable,
   input wire logic smi_pin_enable,
   input wire logic serial_irq_mode,
   input wire logic idle_tick,
   input wire logic [CNT_W-1:0] printer_idle_count,
   input wire logic [CNT_W-1:0] floppy_idle_count,
   input wire logic [CNT_W-1:0] serial_a_idle_count,
   input wire logic [CNT_W-1:0] serial_b_idle_count,
   input wire logic printer_access,
   input wire logic printer_irq,
   input wire logic printer_dack,
   input wire logic [4:0] printer_status_pins,
   input wire logic floppy_access,
   input wire logic floppy_irq,
   input wire logic floppy_dack,
   input wire logic [3:0] floppy_digital_output_reg,
   input wire pm_smi_pkg::uart_act_s serial_a_act,
   input wire logic [3:0] serial_a_modem_pins,
   input wire pm_smi_pkg::uart_act_s serial_b_act,
   input wire logic [3:0] serial_b_modem_pins,
   output logic smi_logic_out,
   output logic smi_out,
   output logic serial_irq_smi_req,
   output logic [3:0] device_sleeping
);
   typedef struct packed {
      logic [7:0] index;
      logic [3:0] sleep_flags;
      logic [3:0] wake_flags;
      logic [3:0] smi_enables;
      logic [7:0] test_reserved;
      logic [7:0] reserved_a;
      logic [7:0] reserved_b;
      logic [7:0] rdata;
      logic smi_logic;
      logic smi;
      logic serirq_req;
      logic [4:0] prt_s1;
      logic [4:0] prt_s2;
      logic [4:0] prt_s3;
      logic [3:0] mdm_a_s1;
      logic [3:0] mdm_a_s2;
      logic [3:0] mdm_a_s3;
      logic [3:0] mdm_b_s1;
      logic [3:0] mdm_b_s2;
      logic [3:0] mdm_b_s3;
      logic [3:0] motor_q;
   } core_regs_s;

   core_regs_s r;
   core_regs_s next_r;

   logic [3:0] irq_lines;
   logic [3:0] enter_sleep;
   logic [3:0] wake;
   logic [3:0] sleeping;
   logic [3:0] activity;
   logic [3:0] idle_ok;
   logic [3:0] w1c_sleep;
   logic [3:0] w1c_wake;
   logic prt_pin_edge;
   logic mdm_a_edge;
   logic mdm_b_edge;
   logic motor_rise;
   logic cfg_write;
   logic cfg_read;
   logic data_write;
   logic [7:0] read_mux;
   logic [CNT_W-1:0] init_count [4];
   pd_in_s pd_in [4];

   // raw irq lines in register bit order
   always_comb begin
      irq_lines = '0;
      irq_lines[`BIT_PRINTER] = printer_irq;
      irq_lines[`BIT_FLOPPY] = floppy_irq;
      irq_lines[`BIT_SERIAL_A] = serial_a_act.irq;
      irq_lines[`BIT_SERIAL_B] = serial_b_act.irq;
   end

   // transitions seen on synchronised pins, and rises of the unsynchronised floppy motor bits
   assign prt_pin_edge = |(r.prt_s2 ^ r.prt_s3);
   assign mdm_a_edge = |(r.mdm_a_s2 ^ r.mdm_a_s3);
   assign mdm_b_edge = |(r.mdm_b_s2 ^ r.mdm_b_s3);
   assign motor_rise = |(floppy_digital_output_reg & ~r.motor_q);

   // wake causes and sleep qualifiers per device
   always_comb begin
      activity = '0;
      idle_ok = '0;
      activity[`BIT_PRINTER] = printer_access | printer_irq | printer_dack | prt_pin_edge;
      idle_ok[`BIT_PRINTER] = ~prt_pin_edge;
      activity[`BIT_FLOPPY] = floppy_access | floppy_irq | floppy_dack | motor_rise;
      idle_ok[`BIT_FLOPPY] = ~|floppy_digital_output_reg;
      activity[`BIT_SERIAL_A] = serial_a_act.access | serial_a_act.irq | serial_a_act.rx_start
                              | serial_a_act.tx_start | mdm_a_edge;
      idle_ok[`BIT_SERIAL_A] = serial_a_act.rx_idle & serial_a_act.tx_empty & ~mdm_a_edge;
      activity[`BIT_SERIAL_B] = serial_b_act.access | serial_b_act.irq | serial_b_act.rx_start
                              | serial_b_act.tx_start | mdm_b_edge;
      idle_ok[`BIT_SERIAL_B] = serial_b_act.rx_idle & serial_b_act.tx_empty & ~mdm_b_edge;
   end

   always_comb begin
      init_count[`BIT_PRINTER] = printer_idle_count;
      init_count[`BIT_FLOPPY] = floppy_idle_count;
      init_count[`BIT_SERIAL_A] = serial_a_idle_count;
      init_count[`BIT_SERIAL_B] = serial_b_idle_count;
   end

   // one power-down machine per device
   for (genvar d = 0; d < `DEV_COUNT; d++) begin : g_pd
      always_comb begin
         pd_in[d].activity = activity[d];
         pd_in[d].idle_ok = idle_ok[d];
         pd_in[d].pm_enable = chip_power_mgmt_enable & device_pm_enable[d];
      end

      pm_power_down #(
         .CNT_W(CNT_W)
      ) u_pd (
         .clk(clk),
         .rstn(rstn),
         .tick(idle_tick),
         .pd_in(pd_in[d]),
         .init_count(init_count[d]),
         .sleeping(sleeping[d]),
         .enter_sleep(enter_sleep[d]),
         .wake(wake[d])
      );
   end

   // host access decode
   assign cfg_write = cfg_req.wr & ext_func_mode;
   assign cfg_read = cfg_req.rd & ext_func_mode;
   assign data_write = cfg_write & cfg_req.data_port;

   always_comb begin
      w1c_sleep = '0;
      w1c_wake = '0;
      if (data_write && r.index == `IDX_SLEEP_FLAGS) begin
         w1c_sleep = cfg_req.wdata[3:0];
      end else if (data_write && r.index == `IDX_WAKE_FLAGS) begin
         w1c_wake = cfg_req.wdata[3:0];
      end
   end

   // read data selection
   always_comb begin
      read_mux = `CFG_RESET_VAL;
      if (!cfg_req.data_port) begin
         read_mux = r.index;
      end else if (r.index == `IDX_TEST_RESERVED) begin
         read_mux = r.test_reserved;
      end else if (r.index == `IDX_SLEEP_FLAGS) begin
         read_mux = {4'h0, r.sleep_flags};
      end else if (r.index == `IDX_WAKE_FLAGS) begin
         read_mux = {4'h0, r.wake_flags};
      end else if (r.index == `IDX_IRQ_MIRROR) begin
         read_mux = {4'h0, irq_lines};
      end else if (r.index == `IDX_RESERVED_A) begin
         read_mux = r.reserved_a;
      end else if (r.index == `IDX_RESERVED_B) begin
         read_mux = r.reserved_b;
      end else if (r.index == `IDX_SMI_ENABLES) begin
         read_mux = {4'h0, r.smi_enables};
      end
   end

   always_comb begin
      next_r = r;
      // two-stage synchronisers and edge history
      next_r.prt_s1 = printer_status_pins;
      next_r.prt_s2 = r.prt_s1;
      next_r.prt_s3 = r.prt_s2;
      next_r.mdm_a_s1 = serial_a_modem_pins;
      next_r.mdm_a_s2 = r.mdm_a_s1;
      next_r.mdm_a_s3 = r.mdm_a_s2;
      next_r.mdm_b_s1 = serial_b_modem_pins;
      next_r.mdm_b_s2 = r.mdm_b_s1;
      next_r.mdm_b_s3 = r.mdm_b_s2;
      next_r.motor_q = floppy_digital_output_reg;

      // index and data port writes
      if (cfg_write && !cfg_req.data_port) begin
         next_r.index = cfg_req.wdata;
      end else if (data_write && r.index == `IDX_TEST_RESERVED) begin
         next_r.test_reserved = cfg_req.wdata;
      end else if (data_write && r.index == `IDX_RESERVED_A) begin
         next_r.reserved_a = cfg_req.wdata;
      end else if (data_write && r.index == `IDX_RESERVED_B) begin
         next_r.reserved_b = cfg_req.wdata;
      end else if (data_write && r.index == `IDX_SMI_ENABLES) begin
         next_r.smi_enables = cfg_req.wdata[3:0];
      end

      // flags: hardware set beats clear
      for (int d = 0; d < `DEV_COUNT; d++) begin
         if (enter_sleep[d]) begin
            next_r.sleep_flags[d] = 1'b1;
         end else if (wake[d] || w1c_sleep[d]) begin
            next_r.sleep_flags[d] = 1'b0;
         end
         if (wake[d]) begin
            next_r.wake_flags[d] = 1'b1;
         end else if (enter_sleep[d] || w1c_wake[d]) begin
            next_r.wake_flags[d] = 1'b0;
         end
      end

      // smi generation
      next_r.smi_logic = |(irq_lines & r.smi_enables);
      next_r.smi = next_r.smi_logic & smi_pin_enable & chip_power_mgmt_enable;
      next_r.serirq_req = next_r.smi & serial_irq_mode;

      // read data held until the next read
      if (cfg_read) begin
         next_r.rdata = read_mux;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
         r.index <= `INDEX_RESET_VAL;
         r.sleep_flags <= `FLAGS_RESET_VAL;
         r.wake_flags <= `FLAGS_RESET_VAL;
         r.smi_enables <= `FLAGS_RESET_VAL;
         r.test_reserved <= `CFG_RESET_VAL;
         r.reserved_a <= `CFG_RESET_VAL;
         r.reserved_b <= `CFG_RESET_VAL;
         r.rdata <= `CFG_RESET_VAL;
      end else begin
         r <= next_r;
      end
   end

   assign cfg_rdata = r.rdata;
   assign smi_logic_out = r.smi_logic;
   assign smi_out = r.smi;
   assign serial_irq_smi_req = r.serirq_req;
   assign device_sleeping = sleeping;
endmodule // pm_status_smi_logic

// *** pm_smi_regs.svh ***
`ifndef PM_SMI_REGS_SVH
`define PM_SMI_REGS_SVH

// configuration indices
`define IDX_TEST_RESERVED 8'h3B
`define IDX_SLEEP_FLAGS 8'h40
`define IDX_WAKE_FLAGS 8'h41
`define IDX_IRQ_MIRROR 8'h42
`define IDX_RESERVED_A 8'h43
`define IDX_RESERVED_B 8'h44
`define IDX_SMI_ENABLES 8'h45

// reset values
`define CFG_RESET_VAL 8'h00
`define FLAGS_RESET_VAL 4'h0
`define INDEX_RESET_VAL 8'h00

// device bit positions in the flag registers
`define BIT_PRINTER 3
`define BIT_FLOPPY 2
`define BIT_SERIAL_A 1
`define BIT_SERIAL_B 0

// widths
`define DEV_COUNT 4
`define CFG_DATA_W 8
`define PRT_PIN_W 5
`define MODEM_PIN_W 4
`define MOTOR_W 4

`endif

// *** pm_smi_pkg.sv ***
package pm_smi_pkg;
   `include "pm_smi_regs.svh"

   typedef enum logic {
      PD_WORK,
      PD_SLEEP
   } pd_state_e;

   // one host access cycle on the index/data port pair
   typedef struct packed {
      logic wr;
      logic rd;
      logic data_port;
      logic [`CFG_DATA_W-1:0] wdata;
   } cfg_req_s;

   // activity and idle qualifiers of one serial port
   typedef struct packed {
      logic access;
      logic irq;
      logic rx_start;
      logic tx_start;
      logic rx_idle;
      logic tx_empty;
   } uart_act_s;

   // generic activity bundle into a power-down machine
   typedef struct packed {
      logic activity;
      logic idle_ok;
      logic pm_enable;
   } pd_in_s;
endpackage

// *** pm_power_down.sv ***
`timescale 1ns/10ps
module pm_power_down
   import pm_smi_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic tick,
   input wire pm_smi_pkg::pd_in_s pd_in,
   input wire logic [CNT_W-1:0] init_count,
   output logic sleeping,
   output logic enter_sleep,
   output logic wake
);
   typedef struct packed {
      pd_state_e state;
      logic [CNT_W-1:0] count;
      logic enter_sleep;
      logic wake;
   } pd_regs_s;

   pd_regs_s r;
   pd_regs_s next_r;

   always_comb begin
      next_r = r;
      next_r.enter_sleep = 1'b0;
      next_r.wake = 1'b0;
      if (!pd_in.pm_enable || init_count == '0) begin
         // disabled or zero count: hold the present state
         next_r.count = r.count;
      end else if (pd_in.activity) begin
         next_r.count = init_count;
         if (r.state == PD_SLEEP) begin
            next_r.state = PD_WORK;
            next_r.wake = 1'b1;
         end
      end else if (r.state == PD_WORK) begin
         if (!pd_in.idle_ok) begin
            next_r.count = init_count;
         end else if (tick) begin
            if (r.count <= CNT_W'(1)) begin
               next_r.count = '0;
               next_r.state = PD_SLEEP;
               next_r.enter_sleep = 1'b1;
            end else begin
               next_r.count = r.count - CNT_W'(1);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '{state: PD_WORK, count: '0, enter_sleep: 1'b0, wake: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign sleeping = (r.state == PD_SLEEP);
   assign enter_sleep = r.enter_sleep;
   assign wake = r.wake;
endmodule // pm_power_down

// *** pm_smi_chk.sv ***
`timescale 1ns/10ps
module pm_smi_chk
   import pm_smi_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic chip_power_mgmt_enable,
   input wire logic [3:0] device_pm_enable,
   input wire logic smi_pin_enable,
   input wire logic serial_irq_mode,
   input wire logic idle_tick,
   input wire logic [CNT_W-1:0] printer_idle_count,
   input wire logic [CNT_W-1:0] floppy_idle_count,
   input wire logic printer_access,
   input wire logic printer_irq,
   input wire logic floppy_access,
   input wire logic floppy_irq,
   input wire logic floppy_dack,
   input wire pm_smi_pkg::uart_act_s serial_a_act,
   input wire pm_smi_pkg::uart_act_s serial_b_act,
   input wire logic smi_logic_out,
   input wire logic smi_out,
   input wire logic serial_irq_smi_req,
   input wire logic [3:0] device_sleeping
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_smi_pin_gate: assert property (
      smi_out == (smi_logic_out && $past(smi_pin_enable) && $past(chip_power_mgmt_enable)))
      else $error("smi pin gating wrong");
   a_serial_req_gate: assert property (
      serial_irq_smi_req == (smi_out && $past(serial_irq_mode)))
      else $error("serial smi request gating wrong");
   a_smi_no_irq: assert property (
      !(printer_irq || floppy_irq || serial_a_act.irq || serial_b_act.irq) |=> !smi_logic_out)
      else $error("smi without any irq");
   a_sleep_on_tick: assert property (
      |(device_sleeping & ~$past(device_sleeping)) |-> $past(idle_tick))
      else $error("sleep entered without tick");
   a_printer_wake: assert property (
      printer_access && device_pm_enable[3] && chip_power_mgmt_enable && printer_idle_count != 0
      |=> !device_sleeping[3])
      else $error("printer stays asleep");
   a_floppy_wake: assert property (
      (floppy_access || floppy_irq || floppy_dack) && device_pm_enable[2] && chip_power_mgmt_enable
      && floppy_idle_count != 0 |=> !device_sleeping[2])
      else $error("floppy stays asleep");
   a_serial_idle_qual: assert property (
      $rose(device_sleeping[1]) |-> $past(serial_a_act.rx_idle) && $past(serial_a_act.tx_empty))
      else $error("serial port slept while busy");
   a_frozen_off: assert property (
      !chip_power_mgmt_enable |=> $stable(device_sleeping))
      else $error("machine moved while disabled");
endmodule // pm_smi_chk

bind pm_status_smi_logic pm_smi_chk #(.CNT_W(CNT_W)) u_pm_smi_chk (.clk, .rstn, .chip_power_mgmt_enable,
   .device_pm_enable, .smi_pin_enable, .serial_irq_mode, .idle_tick, .printer_idle_count, .floppy_idle_count,
   .printer_access, .printer_irq, .floppy_access, .floppy_irq, .floppy_dack, .serial_a_act, .serial_b_act,
   .smi_logic_out, .smi_out, .serial_irq_smi_req, .device_sleeping);

// *** pm_host.sv ***
`timescale 1ns/10ps
module pm_host
   import pm_smi_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] cfg_rdata,
   output pm_smi_pkg::cfg_req_s cfg_req,
   output logic ext_func_mode
);
   initial begin
      cfg_req = '0;
      ext_func_mode = 1'b1;
   end
   // one cycle per access; released bus shows inverted data
   task automatic acc(input logic w, input logic dp, input logic [7:0] d);
      @(negedge clk);
      cfg_req = '{wr: w, rd: !w, data_port: dp, wdata: d};
      @(negedge clk);
      cfg_req = '{wr: 1'b0, rd: 1'b0, data_port: !dp, wdata: ~d};
   endtask
   task automatic put(input logic [7:0] idx, input logic [7:0] d);
      acc(1'b1, 1'b0, idx);
      acc(1'b1, 1'b1, d);
   endtask
   task automatic get(input logic [7:0] idx, output logic [7:0] d);
      acc(1'b1, 1'b0, idx);
      acc(1'b0, 1'b1, 8'h00);
      d = cfg_rdata;
   endtask
endmodule // pm_host

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
   import pm_smi_pkg::*;
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
   logic clk, rstn, chip, pin_en, sirq, tick, p_acc, p_irq, f_acc, f_irq, dk, efm, smi_l, smi, sreq;
   logic [3:0] pm_en, motor, ma, mb, dsl;
   logic [4:0] pst;
   logic [7:0] cnt, rd, rdata, v, r;
   logic [7:0] idx [6] = '{8'h3B, 8'h40, 8'h41, 8'h43, 8'h44, 8'h45};
   uart_act_s ua, ub;
   cfg_req_s req;
   int fails, tests_run;
   pm_status_smi_logic #(.CNT_W(8)) u_pm_status_smi_logic (
      .clk(clk), .rstn(rstn), .cfg_req(req), .ext_func_mode(efm), .cfg_rdata(rdata),
      .chip_power_mgmt_enable(chip), .device_pm_enable(pm_en), .smi_pin_enable(pin_en),
      .serial_irq_mode(sirq), .idle_tick(tick), .printer_idle_count(cnt), .floppy_idle_count(cnt),
      .serial_a_idle_count(cnt), .serial_b_idle_count(cnt), .printer_access(p_acc),
      .printer_irq(p_irq), .printer_dack(dk), .printer_status_pins(pst), .floppy_access(f_acc),
      .floppy_irq(f_irq), .floppy_dack(dk), .floppy_digital_output_reg(motor), .serial_a_act(ua),
      .serial_a_modem_pins(ma), .serial_b_act(ub), .serial_b_modem_pins(mb), .smi_logic_out(smi_l),
      .smi_out(smi), .serial_irq_smi_req(sreq), .device_sleeping(dsl));
   pm_host u_pm_host (.clk(clk), .cfg_rdata(rdata), .cfg_req(req), .ext_func_mode(efm));
   function automatic logic smi_exp(input logic [3:0] irq, input logic [3:0] en);
      return |(irq & en);
   endfunction
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge clk);
         tick = 1'b1;
         @(negedge clk);
         tick = 1'b0;
         repeat (3) @(negedge clk);
      end
   endtask
   task automatic act();
      @(negedge clk);
      {p_acc, f_acc, dk, ua.access, ub.access} = '1;
      @(negedge clk);
      {p_acc, f_acc, dk, ua.access, ub.access} = '0;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #400000;
      fails++;
      conclude();
   end
   initial begin
      {rstn, chip, pin_en, sirq, tick, p_acc, p_irq, f_acc, f_irq, dk} = '0;
      {pm_en, motor, ma, mb, pst, cnt} = '0;
      ua = 6'h03;
      ub = 6'h03;
      void'($urandom(32'h8EF7));
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      foreach (idx[i]) begin
         u_pm_host.get(idx[i], rd);
         `CHK("reset value", 8'h00, rd)
      end
      for (int i = 0; i < 24; i++) begin
         v = $urandom;
         r = (i == 0) ? 8'h7F : $urandom;
         {p_irq, f_irq, ua.irq, ub.irq} = r[3:0];
         {pin_en, chip, sirq} = r[6:4];
         u_pm_host.put(8'h45, v);
         repeat (2) @(negedge clk);
         `CHK("smi logic", smi_exp(r[3:0], v[3:0]), smi_l)
         `CHK("smi pin", smi_exp(r[3:0], v[3:0]) & r[6] & r[5], smi)
         `CHK("serial smi", smi_exp(r[3:0], v[3:0]) & r[6] & r[5] & r[4], sreq)
         u_pm_host.put(8'h42, 8'hFF);
         u_pm_host.get(8'h42, rd);
         `CHK("irq mirror", {4'h0, r[3:0]}, rd)
         u_pm_host.get(8'h45, rd);
         `CHK("smi enables", {4'h0, v[3:0]}, rd)
      end
      {p_irq, f_irq, ua.irq, ub.irq, pin_en} = '0;
      {pm_en, chip, cnt} = {4'hF, 1'b1, 8'h02};
      act();
      ticks(2);
      `CHK("sleeping", 4'hF, dsl)
      u_pm_host.get(8'h40, rd);
      `CHK("sleep flags", 8'h0F, rd)
      u_pm_host.get(8'h41, rd);
      `CHK("wake flags", 8'h00, rd)
      u_pm_host.put(8'h40, 8'hF5);
      u_pm_host.put(8'h40, 8'h00);
      u_pm_host.get(8'h40, rd);
      `CHK("w1c", 8'h0A, rd)
      motor = 4'h1 << ($urandom % 4);
      pst[$urandom % 5] ^= 1'b1;
      ma ^= 4'h1 << ($urandom % 4);
      ub.rx_start = 1'b1;
      @(negedge clk);
      {motor, ub.rx_start} = '0;
      repeat (8) @(negedge clk);
      `CHK("awake", 4'h0, dsl)
      u_pm_host.get(8'h41, rd);
      `CHK("wake set", 8'h0F, rd)
      u_pm_host.put(8'h41, 8'h03);
      u_pm_host.get(8'h41, rd);
      `CHK("wake w1c", 8'h0C, rd)
      u_pm_host.get(8'h40, rd);
      `CHK("sleep cleared", 8'h00, rd)
      ticks(1);
      `CHK("reloaded", 4'h0, dsl)
      ticks(1);
      `CHK("asleep again", 4'hF, dsl)
      u_pm_host.get(8'h41, rd);
      `CHK("wake cleared", 8'h00, rd)
      u_pm_host.put(8'h45, 8'h0A);
      u_pm_host.ext_func_mode = 1'b0;
      u_pm_host.put(8'h45, 8'h05);
      u_pm_host.ext_func_mode = 1'b1;
      u_pm_host.get(8'h45, rd);
      `CHK("mode gate", 8'h0A, rd)
      u_pm_host.acc(1'b0, 1'b0, 8'h00);
      `CHK("index read", 8'h45, rdata)
      conclude();
   end
endmodule // tb
